// ---- src/analog_die_irq_aggregator.sv ----
// Our own choice: the APB interface to the registers.
module analog_die_irq_aggregator (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // source events from the analog die, asynchronous levels
    input wire logic converter_single_done,
    input wire logic converter_sequence_done,
    input wire logic digital_compare_event,
    input wire logic analog_compare_event,
    input wire logic current_dac_thermal_shutdown,
    input wire logic current_dac_ref_resistor_fault,
    input wire logic read_check_error,
    input wire logic write_check_error,
    // lines toward the digital die interrupt controller
    output logic irq_line0,
    output logic irq_line1
);

    localparam int N = lv_irq_pkg::SOURCE_COUNT;

    typedef struct packed {
        logic [N-1:0] sync1;
        logic [N-1:0] sync2;
        logic [N-1:0] prev;
        logic [N-1:0] status;
        logic [2*N-1:0] select;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic line0;
        logic line1;
    } state_t;

    state_t q;
    state_t d;

    logic [N-1:0] src_raw;
    logic [N-1:0] rise;
    logic [N-1:0] clr_mask;
    logic setup;
    logic access_done;
    logic hit_clr;
    logic hit_sel;
    logic hit_sta;

    // ****************************************
    // source packing
    // ****************************************
    always_comb begin
        src_raw = '0;
        src_raw[lv_irq_pkg::BIT_CONVERTER_SINGLE_DONE] = converter_single_done; // see R3
        src_raw[lv_irq_pkg::BIT_CONVERTER_SEQUENCE_DONE] = converter_sequence_done; // see R4
        src_raw[lv_irq_pkg::BIT_DIGITAL_COMPARE_EVENT] = digital_compare_event; // see R6
        src_raw[lv_irq_pkg::BIT_ANALOG_COMPARE_EVENT] = analog_compare_event; // see R5
        src_raw[lv_irq_pkg::BIT_CURRENT_DAC_THERMAL_SHUTDOWN] =
            current_dac_thermal_shutdown; // see R7
        src_raw[lv_irq_pkg::BIT_CURRENT_DAC_REF_RESISTOR_FAULT] =
            current_dac_ref_resistor_fault; // see R7
        src_raw[lv_irq_pkg::BIT_READ_CHECK_ERROR] = read_check_error; // see R8
        src_raw[lv_irq_pkg::BIT_WRITE_CHECK_ERROR] = write_check_error; // see R9
    end

    // ****************************************
    // address decode
    // ****************************************
    always_comb begin
        hit_clr = 1'b0;
        hit_sel = 1'b0;
        hit_sta = 1'b0;
        if (paddr == lv_irq_pkg::IRQ_FLAG_CLEAR_ADDR) begin
            hit_clr = 1'b1;
        end else if (paddr == lv_irq_pkg::IRQ_LINE_SELECT_ADDR) begin
            hit_sel = 1'b1;
        end else if (paddr == lv_irq_pkg::IRQ_SOURCE_STATUS_ADDR) begin
            hit_sta = 1'b1;
        end
    end

    assign setup = psel && !penable;
    assign access_done = psel && penable && q.ready;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.sync1 = src_raw;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        rise = q.sync2 & ~q.prev;

        // no wait state: answer registered during setup, ready in the first access cycle
        d.ready = setup;
        d.slverr = 1'b0;
        d.rdata = '0;
        if (setup) begin
            d.slverr = !(hit_clr || hit_sel || hit_sta);
            if (!pwrite && hit_sel) begin
                d.rdata = {16'h0000, q.select};
            end else if (!pwrite && hit_sta) begin
                d.rdata = {24'h00_0000, q.status}; // see R11 see R14
            end
        end else if (psel && penable && !q.ready) begin
            d.rdata = q.rdata;
        end

        clr_mask = '0;
        if (access_done && pwrite && hit_clr && pstrb[0]) begin
            clr_mask = pwdata[N-1:0]; // see R15
        end
        if (access_done && pwrite && hit_sel) begin
            if (pstrb[0]) begin
                d.select[7:0] = pwdata[7:0]; // see R10
            end
            if (pstrb[1]) begin
                d.select[15:8] = pwdata[15:8]; // see R13 see R12
            end
        end

        // sticky flags, a new event wins over a clear in the same cycle
        d.status = (q.status & ~clr_mask) | rise; // see R17 see R2

        d.line1 = |(d.status & d.select[lv_irq_pkg::LINE1_SEL_LSB +: N]); // see R1 see R17
        d.line0 = |(d.status & d.select[lv_irq_pkg::LINE0_SEL_LSB +: N]); // see R1 see R17
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.status <= lv_irq_pkg::IRQ_SOURCE_STATUS_RESET; // see R18
            q.select <= lv_irq_pkg::IRQ_LINE_SELECT_RESET; // see R18
        end else begin
            q <= d;
        end
    end

    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.slverr && q.ready;
    assign irq_line0 = q.line0;
    assign irq_line1 = q.line1;

endmodule // analog_die_irq_aggregator

// ---- src/lv_irq_pkg.sv ----
// Behaviour
// R1: two interrupt outputs, each multiplexed from sources
// R2: status bits 7..0 map fixed sources
// R3: single conversion end sets bit 0
// R4: sequence completion sets bit 1
// R5: analog compare out-of-threshold sets bit 3
// R6: digital compare out-of-threshold sets bit 2
// R7: thermal shutdown and resistor fault separate flags
// R8: read check error sets bit 6
// R9: write check error sets bit 7
// R10: line 1 enables any mix, bits 7:0
// R11: status shows which source fired line 1
// R12: software enables one line 0 source only; code accepts any mix in select bits 15:8 and ORs them
// R13: select bits 15:8 enable line 0 sources
// R14: status not valid for line 0 source
// R15: writing one to clear bit clears flag
// R16: software waits before reading status after clear
// R17: flags sticky until cleared; lines follow flags
// R18: selects and flags zero after reset
package lv_irq_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [31:0] IRQ_FLAG_CLEAR_ADDR = 32'h4008_3004;
    localparam logic [31:0] IRQ_LINE_SELECT_ADDR = 32'h4008_3008;
    localparam logic [31:0] IRQ_SOURCE_STATUS_ADDR = 32'h4008_300C;

    localparam logic [15:0] IRQ_LINE_SELECT_RESET = 16'h0000;
    localparam logic [7:0] IRQ_SOURCE_STATUS_RESET = 8'h00;

    // ****************************************
    // field layout
    // ****************************************
    localparam int SOURCE_COUNT = 8;
    localparam int LINE1_SEL_LSB = 0;
    localparam int LINE0_SEL_LSB = 8;

    localparam int BIT_CONVERTER_SINGLE_DONE = 0;
    localparam int BIT_CONVERTER_SEQUENCE_DONE = 1;
    localparam int BIT_DIGITAL_COMPARE_EVENT = 2;
    localparam int BIT_ANALOG_COMPARE_EVENT = 3;
    localparam int BIT_CURRENT_DAC_THERMAL_SHUTDOWN = 4;
    localparam int BIT_CURRENT_DAC_REF_RESISTOR_FAULT = 5;
    localparam int BIT_READ_CHECK_ERROR = 6;
    localparam int BIT_WRITE_CHECK_ERROR = 7;

endpackage : lv_irq_pkg

// ---- verification/irq_host_model.sv ----
module irq_host_model (
    input logic pclk, presetn, irq_line0, irq_line1,
    output logic [7:0] hits0_q, hits1_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic l0_q, l1_q;
    // counts interrupt entries per line, as the host controller would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {l0_q, l1_q, hits0_q, hits1_q} <= '0;
        end else begin
            {l0_q, l1_q} <= {irq_line0, irq_line1};
            hits0_q <= hits0_q + 8'(irq_line0 & !l0_q);
            hits1_q <= hits1_q + 8'(irq_line1 & !l1_q);
        end
    end
endmodule // irq_host_model

// ---- verification/irq_props.sv ----
module irq_props (
    input logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_line0, irq_line1,
    input logic [31:0] prdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("late ready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("long ready");
    property p_pair; pready |-> $past(psel && !penable); endproperty
    a_pair: assert property (p_pair) else $error("stray ready");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad error");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("bad idle");
    property p_rst; $rose(presetn) |-> !irq_line0 && !irq_line1; endproperty
    a_rst: assert property (p_rst) else $error("line at reset");
    property p_hold1; irq_line1 && !(psel && penable && pwrite) |=> irq_line1; endproperty
    a_hold1: assert property (p_hold1) else $error("line1 dropped");
    property p_hold0; irq_line0 && !(psel && penable && pwrite) |=> irq_line0; endproperty
    a_hold0: assert property (p_hold0) else $error("line0 dropped");
    c_l0: cover property (irq_line0);
    c_l1: cover property (irq_line1);
    c_err: cover property (pslverr);
endmodule // irq_props

// ---- verification/test_analog_die_irq_aggregator.sv ----
module test_analog_die_irq_aggregator;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] CLR = lv_irq_pkg::IRQ_FLAG_CLEAR_ADDR;
    localparam logic [31:0] SEL = lv_irq_pkg::IRQ_LINE_SELECT_ADDR;
    localparam logic [31:0] STA = lv_irq_pkg::IRQ_SOURCE_STATUS_ADDR;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [31:0] paddr = '0, pwdata = '0, prdata, q;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, irq_line0, irq_line1;
    logic [7:0] src = '0, h0, h1, b;
    int num_errors = 0, tests_run = 0;
    analog_die_irq_aggregator uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_line0(irq_line0),
        .irq_line1(irq_line1), .converter_single_done(src[0]),
        .converter_sequence_done(src[1]), .digital_compare_event(src[2]),
        .analog_compare_event(src[3]), .current_dac_thermal_shutdown(src[4]),
        .current_dac_ref_resistor_fault(src[5]), .read_check_error(src[6]),
        .write_check_error(src[7]));
    irq_host_model host (.pclk(pclk), .presetn(presetn), .irq_line0(irq_line0),
        .irq_line1(irq_line1), .hits0_q(h0), .hits1_q(h1));
    initial forever #50 pclk = ~pclk;
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", n, x, g);
        end
    endtask
    // one apb transfer; read data and error taken at the ready edge
    task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(negedge pclk);
    endtask
    task automatic fire(int i);
        @(posedge pclk);
        src[i] <= 1;
        repeat (3) @(posedge pclk);
        src[i] <= 0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic per_source(int i);
        b = 8'h01 << i;
        bus(1, SEL, {16'h0, b, ~b});
        fire(i);
        chk("line0", 1, irq_line0);
        chk("line1 masked", 0, irq_line1);
        bus(0, STA, 0);
        chk("status", b, q);
        bus(1, SEL, 32'hFF);
        chk("line1", 1, irq_line1);
        bus(1, CLR, 0);
        bus(0, STA, 0);
        chk("status kept", b, q);
        bus(1, CLR, b);
        bus(0, STA, 0);
        chk("status cleared", 0, q);
        chk("line1 off", 0, irq_line1);
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200us;
        num_errors++;
        test_done;
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        bus(0, SEL, 0);
        chk("select reset", 0, q);
        bus(1, STA, 32'hFF);
        bus(0, STA, 0);
        chk("status reset", 0, q);
        bus(0, CLR, 0);
        chk("clear read", 0, q);
        bus(0, CLR + 32'h0C, 0);
        chk("unmapped", 1, e);
        for (int i = 0; i < 8; i++) per_source(i);
        chk("line0 entries", 8, h0);
        chk("line1 entries", 8, h1);
        test_done;
    end
endmodule // test_analog_die_irq_aggregator
bind analog_die_irq_aggregator irq_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .irq_line0(irq_line0), .irq_line1(irq_line1), .prdata(prdata));
